// File: src/adc_output_data_formatter.sv
// output data formatter of a 12-bit sampling converter
// assumes samples from the converter core on sys_clk, one per cycle when valid;
// configuration writes arrive on sys_clk from the serial port logic
`timescale 1ns/1ps
`include "fmt_cfg.svh"
module adc_output_data_formatter (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             cfg_wr_en,
  input  wire logic [7:0]       cfg_addr,
  input  wire logic [7:0]       cfg_wdata,
  output logic [7:0]            cfg_rdata,
  input  wire logic             sample_valid,
  input  wire fmt_pkg::sample_t sample_in,
  input  wire logic             overrange_in,
  output logic                  out_valid,
  output fmt_pkg::sample_t      sample_data_bits,
  output logic                  overrange_flag_out
);
  logic [7:0]        data_format_control_q;
  logic              phase_q;
  fmt_pkg::pattern_t test_pattern_select;
  logic              alternate_polarity_enable;
  logic              output_scramble_enable;
  logic              signed_coding_select;
  fmt_pkg::sample_t  coded;
  logic [12:0]       word_d;

  // bits 7:6 stored but have no effect
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_format_control_q <= `FMT_REG_RESET;
    end else if (cfg_wr_en && cfg_addr == `FMT_REG_ADDR) begin
      data_format_control_q <= cfg_wdata;
    end
  end

  // readback registered so the output comes from a flip-flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_rdata <= 8'h00;
    end else begin
      cfg_rdata <= (cfg_addr == `FMT_REG_ADDR) ? data_format_control_q : 8'h00;
    end
  end

  assign test_pattern_select       = data_format_control_q[`FMT_TP_MSB:`FMT_TP_LSB];
  assign alternate_polarity_enable = data_format_control_q[`FMT_BIT_ALTPOL];
  assign output_scramble_enable    = data_format_control_q[`FMT_BIT_SCRAMBLE];
  assign signed_coding_select      = data_format_control_q[`FMT_BIT_CODING];

  sample_coder u_coder (
    .raw                       (sample_in),
    .signed_coding_select      (signed_coding_select),
    .output_scramble_enable    (output_scramble_enable),
    .alternate_polarity_enable (alternate_polarity_enable),
    .coded                     (coded)
  );

  // pattern phase flips once per sample
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_q <= 1'b0;
    end else if (sample_valid) begin
      phase_q <= ~phase_q;
    end
  end

  // undefined patterns fall back to normal data; software must avoid them
  always_comb begin
    unique case (test_pattern_select)
      `FMT_TP_ZEROS:   word_d = 13'h0000;
      `FMT_TP_ONES:    word_d = 13'h1FFF;
      `FMT_TP_CHECKER: word_d = phase_q ? `FMT_CHECKER_B : `FMT_CHECKER_A;
      `FMT_TP_TOGGLE:  word_d = phase_q ? 13'h1FFF : 13'h0000;
      default:         word_d = {overrange_in, coded};
    endcase
  end

  // data and overrange outputs hold between samples so slow capture logic sees a stable word; out_valid follows sample_valid
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= sample_valid;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sample_data_bits <= 12'h000;
    end else if (sample_valid) begin
      sample_data_bits <= word_d[11:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overrange_flag_out <= 1'b0;
    end else if (sample_valid) begin
      overrange_flag_out <= word_d[12];
    end
  end

  AST_ZEROS: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && test_pattern_select == `FMT_TP_ZEROS
    |=> {overrange_flag_out, sample_data_bits} == 13'h0000)
    else $error("zeros pattern wrong");
  AST_ONES: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && test_pattern_select == `FMT_TP_ONES
    |=> {overrange_flag_out, sample_data_bits} == 13'h1FFF)
    else $error("ones pattern wrong");
  AST_CHECKER: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && test_pattern_select == `FMT_TP_CHECKER
    |=> ({overrange_flag_out, sample_data_bits} == `FMT_CHECKER_A) ||
        ({overrange_flag_out, sample_data_bits} == `FMT_CHECKER_B))
    else $error("checkerboard word wrong");
  AST_CHECKER_ALT: assert property (@(posedge sys_clk) disable iff (rst)
    (sample_valid && test_pattern_select == `FMT_TP_CHECKER) [*2]
    |=> {overrange_flag_out, sample_data_bits} == ~$past({overrange_flag_out, sample_data_bits}))
    else $error("checkerboard did not alternate");
  AST_TOGGLE_ALT: assert property (@(posedge sys_clk) disable iff (rst)
    (sample_valid && test_pattern_select == `FMT_TP_TOGGLE) [*2]
    |=> {overrange_flag_out, sample_data_bits} == ~$past({overrange_flag_out, sample_data_bits}))
    else $error("toggle pattern did not alternate");
  AST_PASS_OF: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && test_pattern_select == `FMT_TP_OFF |=> overrange_flag_out == $past(overrange_in))
    else $error("overrange not passed");
  AST_PLAIN: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && test_pattern_select == `FMT_TP_OFF && data_format_control_q[2:0] == 3'h0
    |=> sample_data_bits == $past(sample_in))
    else $error("offset binary pass wrong");
  AST_SIGNED: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && test_pattern_select == `FMT_TP_OFF && data_format_control_q[2:0] == 3'h1
    |=> sample_data_bits == ($past(sample_in) ^ `FMT_MSB_FLIP))
    else $error("two's complement wrong");
  AST_ALTPOL: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && test_pattern_select == `FMT_TP_OFF && data_format_control_q[2:1] == 2'h2
    |=> sample_data_bits == ($past(sample_in) ^ `FMT_ALTPOL_MASK))
    else $error("alternate polarity wrong");
  AST_SCRAMBLE: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && test_pattern_select == `FMT_TP_OFF && data_format_control_q[2:0] == 3'h2
    |=> (sample_data_bits ^ {{11{sample_data_bits[0]}}, 1'b0}) == $past(sample_in))
    else $error("scramble not reversible");
  // scrambled checks undo the xor instead of rebuilding it, so a shared slip still shows
  AST_SCR_SIGNED: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && test_pattern_select == `FMT_TP_OFF && data_format_control_q[2:0] == 3'h3
    |=> (sample_data_bits ^ {{11{sample_data_bits[0]}}, 1'b0})
        == ($past(sample_in) ^ `FMT_MSB_FLIP))
    else $error("scrambled two's complement wrong");
  AST_SCR_ALTPOL: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && test_pattern_select == `FMT_TP_OFF && data_format_control_q[2:1] == 2'h3
    |=> (sample_data_bits ^ `FMT_ALTPOL_MASK ^ {{11{sample_data_bits[0]}}, 1'b0})
        == $past(sample_in))
    else $error("scrambled alternate polarity wrong");

  // output timing and pattern phase
  AST_OUT_VALID: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> out_valid == $past(sample_valid))
    else $error("output strobe not one cycle after sample");
  AST_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    !sample_valid |=> $stable({overrange_flag_out, sample_data_bits}))
    else $error("output word moved without a sample");
  AST_PHASE: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid |=> phase_q != $past(phase_q))
    else $error("pattern phase did not advance");
  AST_PHASE_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    !sample_valid |=> $stable(phase_q))
    else $error("pattern phase moved without a sample");
  AST_CHECKER_FIRST: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && test_pattern_select == `FMT_TP_CHECKER && !phase_q
    |=> {overrange_flag_out, sample_data_bits} == `FMT_CHECKER_A)
    else $error("checkerboard phase word wrong");
  AST_TOGGLE_FIRST: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && test_pattern_select == `FMT_TP_TOGGLE && !phase_q
    |=> {overrange_flag_out, sample_data_bits} == 13'h0000)
    else $error("toggle phase word wrong");
  AST_TOGGLE_VAL: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && test_pattern_select == `FMT_TP_TOGGLE
    |=> ({overrange_flag_out, sample_data_bits} == 13'h0000) ||
        ({overrange_flag_out, sample_data_bits} == 13'h1FFF))
    else $error("toggle word not all zeros or all ones");

  // register path
  AST_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    cfg_wr_en && cfg_addr == `FMT_REG_ADDR |=> data_format_control_q == $past(cfg_wdata))
    else $error("format register write lost");
  AST_NO_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    !(cfg_wr_en && cfg_addr == `FMT_REG_ADDR) |=> $stable(data_format_control_q))
    else $error("format register changed without a write");
  // readback one cycle late; the serial side has that cycle to spare
  AST_READBACK: assert property (@(posedge sys_clk) disable iff (rst)
    cfg_addr == `FMT_REG_ADDR |=> cfg_rdata == $past(data_format_control_q))
    else $error("format register readback wrong");
  AST_OTHER_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
    cfg_addr != `FMT_REG_ADDR |=> cfg_rdata == 8'h00)
    else $error("unmapped address read not zero");

  COV_CHECKER: cover property (@(posedge sys_clk) disable iff (rst)
    (sample_valid && test_pattern_select == `FMT_TP_CHECKER) [*3]);
  COV_TOGGLE: cover property (@(posedge sys_clk) disable iff (rst)
    (sample_valid && test_pattern_select == `FMT_TP_TOGGLE) [*3]);
  COV_SCR_ALT: cover property (@(posedge sys_clk) disable iff (rst)
    sample_valid && data_format_control_q[2:1] == 2'h3);
  COV_SIGNED_ALTPOL: cover property (@(posedge sys_clk) disable iff (rst)
    sample_valid && test_pattern_select == `FMT_TP_OFF && data_format_control_q[2:0] == 3'h5);
  COV_WRITE_IGNORED: cover property (@(posedge sys_clk) disable iff (rst)
    cfg_wr_en && cfg_addr != `FMT_REG_ADDR);
endmodule : adc_output_data_formatter

// File: src/fmt_cfg.svh
// constants of the output data formatter: register offset, field positions, patterns
// assumes inclusion by bare name from the package and the design modules
`ifndef FMT_CFG_SVH
`define FMT_CFG_SVH
`define FMT_REG_ADDR      8'h04
`define FMT_REG_RESET     8'h00
`define FMT_BIT_CODING    0
`define FMT_BIT_SCRAMBLE  1
`define FMT_BIT_ALTPOL    2
`define FMT_TP_LSB        3
`define FMT_TP_MSB        5
`define FMT_TP_OFF        3'h0
`define FMT_TP_ZEROS      3'h1
`define FMT_TP_ONES       3'h3
`define FMT_TP_CHECKER    3'h5
`define FMT_TP_TOGGLE     3'h7
`define FMT_CHECKER_A     13'h1555
`define FMT_CHECKER_B     13'h0AAA
`define FMT_ALTPOL_MASK   12'hAAA
`define FMT_MSB_FLIP      12'h800
`endif

// File: src/fmt_pkg.sv
// types of the output data formatter
// assumes fmt_cfg.svh on the include path
`include "fmt_cfg.svh"
package fmt_pkg;
  typedef logic [11:0] sample_t;
  typedef logic [2:0]  pattern_t;
endpackage : fmt_pkg

// File: src/sample_coder.sv
// combinational coding of one sample: signed coding, scramble, alternate polarity
// assumes a registered caller; pure logic, no state
`timescale 1ns/1ps
`include "fmt_cfg.svh"
module sample_coder (
  input  wire fmt_pkg::sample_t raw,
  input  wire logic             signed_coding_select,
  input  wire logic             output_scramble_enable,
  input  wire logic             alternate_polarity_enable,
  output fmt_pkg::sample_t      coded
);
  fmt_pkg::sample_t coded_bin;
  fmt_pkg::sample_t scrambled;

  // alternate polarity overrides signed coding
  assign coded_bin = (signed_coding_select && !alternate_polarity_enable)
                     ? (raw ^ `FMT_MSB_FLIP) : raw;

  // lsb passes through unscrambled so the receiver can undo the xor
  genvar i;
  generate
    for (i = 0; i < 12; i++) begin : g_scr
      if (i == 0) begin : g_lsb
        assign scrambled[i] = coded_bin[0];
      end else begin : g_up
        assign scrambled[i] = output_scramble_enable
                              ? (coded_bin[i] ^ coded_bin[0]) : coded_bin[i];
      end
    end
  endgenerate

  assign coded = alternate_polarity_enable
                 ? (scrambled ^ `FMT_ALTPOL_MASK) : scrambled;
endmodule : sample_coder

// File: bench/capture_model.sv
// capture side model: recovers the raw sample from a formatted word
// assumes format bits 2:0 as last written, and pattern mode off
`timescale 1ns/1ps
`include "fmt_cfg.svh"
module capture_model (
  input  wire fmt_pkg::sample_t sample_data_bits,
  input  wire logic [2:0]       fmt_bits,
  output fmt_pkg::sample_t      recovered
);
  // undo in reverse order of coding
  always_comb begin
    recovered = sample_data_bits;
    if (fmt_bits[2]) recovered = recovered ^ `FMT_ALTPOL_MASK;
    if (fmt_bits[1]) recovered[11:1] = recovered[11:1] ^ {11{recovered[0]}};
    if (fmt_bits[0] && !fmt_bits[2]) recovered = recovered ^ `FMT_MSB_FLIP;
  end
endmodule : capture_model

// File: bench/adc_output_data_formatter_tb.sv
// bench of the output data formatter: register tasks, sample stream, queued expectations
// assumes one sys_clk domain, samples one per cycle
`timescale 1ns/1ps
`include "fmt_cfg.svh"
module adc_output_data_formatter_tb;
  logic             sys_clk, rst, cfg_wr_en, sample_valid, overrange_in;
  logic             out_valid, overrange_flag_out, phase;
  logic [7:0]       cfg_addr, cfg_wdata, cfg_rdata, cfg_copy;
  fmt_pkg::sample_t sample_in, sample_data_bits, recovered;
  logic [12:0]      exp_q[$];
  fmt_pkg::sample_t raw_q[$];
  int               err_total, tests_run;
  localparam fmt_pkg::pattern_t pattern_list [4] =
    '{`FMT_TP_ZEROS, `FMT_TP_ONES, `FMT_TP_CHECKER, `FMT_TP_TOGGLE};
  adc_output_data_formatter u_adc_output_data_formatter (.sys_clk(sys_clk), .rst(rst),
    .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .sample_valid(sample_valid), .sample_in(sample_in), .overrange_in(overrange_in),
    .out_valid(out_valid), .sample_data_bits(sample_data_bits),
    .overrange_flag_out(overrange_flag_out));
  capture_model u_capture_model (.sample_data_bits(sample_data_bits),
    .fmt_bits(cfg_copy[2:0]), .recovered(recovered));
  task automatic check(string what, logic [12:0] seen, logic [12:0] want);
    tests_run++;
    if (seen !== want) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic write_reg(logic [7:0] a, logic [7:0] v);
    @(posedge sys_clk);
    cfg_wr_en <= 1'b1;
    cfg_addr  <= a;
    cfg_wdata <= v;
    @(posedge sys_clk);
    cfg_wr_en <= 1'b0;
    if (a == `FMT_REG_ADDR) cfg_copy = v;
  endtask : write_reg
  task automatic read_reg(logic [7:0] a, logic [7:0] want);
    @(posedge sys_clk);
    cfg_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check("cfg_rdata", {5'h00, cfg_rdata}, {5'h00, want});
  endtask : read_reg
  // expectation queued before the drive edge; the monitor pops it
  task automatic send(fmt_pkg::sample_t raw, logic ovr);
    fmt_pkg::sample_t d;
    d = raw;
    if (cfg_copy[0] && !cfg_copy[2]) d = d ^ `FMT_MSB_FLIP;
    if (cfg_copy[1]) d[11:1] = d[11:1] ^ {11{d[0]}};
    if (cfg_copy[2]) d = d ^ `FMT_ALTPOL_MASK;
    case (cfg_copy[`FMT_TP_MSB:`FMT_TP_LSB])
      `FMT_TP_ZEROS:   exp_q.push_back(13'h0000);
      `FMT_TP_ONES:    exp_q.push_back(13'h1FFF);
      `FMT_TP_CHECKER: exp_q.push_back(phase ? `FMT_CHECKER_B : `FMT_CHECKER_A);
      `FMT_TP_TOGGLE:  exp_q.push_back(phase ? 13'h1FFF : 13'h0000);
      default:         exp_q.push_back({ovr, d});
    endcase
    raw_q.push_back(raw);
    phase = ~phase;
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    sample_in    <= raw;
    overrange_in <= ovr;
  endtask : send
  task automatic idle;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
  endtask : idle
  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  always @(negedge sys_clk) if (out_valid === 1'b1) begin
    check("word", {overrange_flag_out, sample_data_bits}, exp_q.pop_front());
    if (cfg_copy[5:3] == 3'h0) check("recovered", {1'b0, recovered}, {1'b0, raw_q[0]});
    raw_q.delete(0);
  end
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // about 117 cycles expected; margin for stalls
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    test_done();
  end
  initial begin
    {rst, phase} = 2'b10;
    {cfg_wr_en, cfg_addr, cfg_wdata, cfg_copy} = '0;
    {sample_valid, sample_in, overrange_in} = '0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    read_reg(`FMT_REG_ADDR, `FMT_REG_RESET);
    for (int c = 0; c < 8; c++) begin
      write_reg(`FMT_REG_ADDR, {2'b11, 3'h0, c[2:0]});
      read_reg(`FMT_REG_ADDR, {2'b11, 3'h0, c[2:0]});
      send(12'h000, 1'b1);
      send(12'h801, 1'b0);
      send(12'h7FE, 1'b1);
      send(12'hA5C, 1'b0);
      idle();
    end
    foreach (pattern_list[i]) begin
      write_reg(`FMT_REG_ADDR, {2'b00, pattern_list[i], 3'h7});
      repeat (3) send(12'h3C3, 1'b0);
      idle();
    end
    write_reg(8'h05, 8'hFF);
    read_reg(`FMT_REG_ADDR, {2'b00, `FMT_TP_TOGGLE, 3'h7});
    read_reg(8'h05, 8'h00);
    check("pending", 13'(exp_q.size()), 13'h0000);
    test_done();
  end
endmodule : adc_output_data_formatter_tb
